// File: core/dac_port_pkg.sv
// Constants, field layouts and carrier types of the dual DAC serial port
//
// Behaviour
// - Per converter, volatile code sets output
// - Power-up copies nonvolatile codes into volatile
// - Nonvolatile codes read/write, all zero delivered
// - Ignore general call; 7-bit addressing only
// - One bit per rising clock, nine per byte
// - Data stable while clock high; idle high
// - START falls, STOP rises, clock high
// - Repeated START restarts address decoding
// - Honour STOP anywhere except START's high
// - Accept writes chained by repeated STARTs
// - Acknowledge holds data low through ninth clock
// - Address is 010 plus four select pins
// - Act only after START and own address
// - Address LSB: 0 write, 1 read
// - Acknowledge a matching address for one clock
// - Write command: top bits zero, select fields
// - Update on 26th rising edge only
// - Read: command write, repeated START, read address
// - Read command carries 10 in top bits
// - After read address, acknowledge then shift data
// - Pins are inputs; data driven open-drain
// - Volatile write updates converter output immediately
// - Select pair: copy, volatile, nonvolatile, both
// - Converter 0, 1, or all for volatile
// - Busy up to 15 ms after STOP
package dac_port_pkg;

   // Timing
   localparam int CLK_HZ = 20_000_000;
   localparam int BUSY_MS = 15;
   localparam int BUSY_CYCLES = BUSY_MS * (CLK_HZ / 1000);
   localparam int CNT_W = 24;

   // Frame layout: eight data bits then one acknowledge clock
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam int ADDR_PINS = 4;

   // Address and command encodings
   localparam logic [2:0] ADDR_PREFIX = 3'h2;
   localparam logic [1:0] OP_WRITE = 2'h0;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] REG_COPY = 2'h0;
   localparam logic [1:0] REG_VOL = 2'h1;
   localparam logic [1:0] REG_NV = 2'h2;
   localparam logic [1:0] REG_BOTH = 2'h3;
   localparam logic [3:0] SEL_DAC0 = 4'h0;
   localparam logic [3:0] SEL_DAC1 = 4'h1;
   localparam logic [3:0] SEL_ALL = 4'hF;

   // Reset values
   localparam logic [7:0] NV_RESET = 8'h00;
   localparam logic [7:0] VOL_RESET = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;

   typedef struct packed {
      logic [1:0] op;
      logic nonvolatile_select_bit;
      logic volatile_select_bit;
      logic [3:0] register_select_field;
   } cmd_t;

   typedef struct packed {
      logic [7:0] code1;
      logic [7:0] code0;
   } dac_codes_t;

   typedef enum {
      st_idle, st_addr, st_cmd, st_data, st_read, st_ignore
   } bus_state_t;

endpackage

// File: core/sync_2ff.sv
// Two-flop synchroniser for levels entering the reference clock domain
module sync_2ff #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= INIT;
         q <= INIT;
      end else if (clk_en) begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule

// File: core/dual_dac_serial_register_port.sv
// Two-wire target port holding the volatile and nonvolatile DAC codes
module dual_dac_serial_register_port
   import dac_port_pkg::*;
#(
   parameter int BUSY_CNT = BUSY_CYCLES,
   parameter int NUM_SEL_PINS = ADDR_PINS
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic scl_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic [NUM_SEL_PINS-1:0] address_select_pins,
   output logic sda_out,
   output logic sda_oe_n,
   output dac_codes_t dac_codes,
   output dac_codes_t nv_codes,
   output logic nv_busy,
   output logic bus_active
);

   // Elaboration checks
   generate
      if (BUSY_CNT < 1 || BUSY_CNT >= (1 << CNT_W)) begin : g_bad_busy
         $error("BUSY_CNT out of counter range");
      end
      if (NUM_SEL_PINS != ADDR_PINS) begin : g_bad_pins
         $error("Address needs exactly four select pins");
      end
   endgenerate

   localparam logic [CNT_W-1:0] BUSY_LOAD = CNT_W'(BUSY_CNT);

   // Decode helpers
   function automatic logic sel_hits(input logic [3:0] sel,
                                     input int idx);
      sel_hits = (sel == SEL_ALL) || (sel == 4'(idx));
   endfunction

   function automatic logic sel_single(input logic [3:0] sel);
      sel_single = (sel == SEL_DAC0) || (sel == SEL_DAC1);
   endfunction

   function automatic logic write_ok(input cmd_t c);
      logic [1:0] kind;
      kind = {c.nonvolatile_select_bit, c.volatile_select_bit};
      write_ok = (c.op == OP_WRITE) &&
                 (sel_single(c.register_select_field) ||
                  (c.register_select_field == SEL_ALL &&
                   kind == REG_VOL));
   endfunction

   function automatic logic read_ok(input cmd_t c);
      logic [1:0] kind;
      kind = {c.nonvolatile_select_bit, c.volatile_select_bit};
      read_ok = (c.op == OP_READ) &&
                (kind == REG_VOL || kind == REG_NV) &&
                sel_single(c.register_select_field);
   endfunction

   // ---------------- Link domain, clocked by the bus clock ----------
   logic link_bit_q;
   logic link_tog_q;

   // Each rising bus clock samples one data bit and flips a toggle
   always_ff @(posedge scl_clk or negedge resetn) begin
      if (!resetn) begin
         link_bit_q <= 1'b1;
         link_tog_q <= 1'b0;
      end else begin
         link_bit_q <= sda_in;
         link_tog_q <= ~link_tog_q;
      end
   end

   // ---------------- Crossings into the reference domain ------------
   logic [1:0] link_s;
   logic [1:0] pins_s;
   logic [NUM_SEL_PINS-1:0] sel_pins_s;

   sync_2ff #(.WIDTH(2), .INIT(2'h1)) u_link_sync (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .clk_en(clk_en),
      .d({link_tog_q, link_bit_q}),
      .q(link_s)
   );

   // Both bus lines idle high, so their stages reset high
   sync_2ff #(.WIDTH(2), .INIT(2'h3)) u_pin_sync (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .clk_en(clk_en),
      .d({scl_in, sda_in}),
      .q(pins_s)
   );

   sync_2ff #(.WIDTH(NUM_SEL_PINS), .INIT('0)) u_sel_sync (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .clk_en(clk_en),
      .d(address_select_pins),
      .q(sel_pins_s)
   );

   logic tog_s;
   logic bit_s;
   logic scl_s;
   logic sda_s;
   assign tog_s = link_s[1];
   assign bit_s = link_s[0];
   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   // ---------------- Line events ----------------------------------
   logic tog_q;
   logic bit_ev_q;
   logic scl_p_q;
   logic sda_p_q;
   logic start_hi_q;

   // The bit is used one cycle after its toggle, so a skew between
   // the two synchronised lanes cannot deliver a stale bit
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         tog_q <= 1'b0;
         bit_ev_q <= 1'b0;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end else if (clk_en) begin
         tog_q <= tog_s;
         bit_ev_q <= tog_s ^ tog_q;
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   logic start_ev;
   logic stop_ev;
   logic stop_ok;
   logic scl_fall;
   // Data edges while the clock is high are control conditions
   assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s;
   assign scl_fall = scl_p_q & ~scl_s;
   // A STOP inside the high pulse that carried a START is illegal
   assign stop_ok = stop_ev & ~start_hi_q;

   // Remember a START until the clock falls again
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         start_hi_q <= 1'b0;
      end else if (clk_en) begin
         if (start_ev) begin
            start_hi_q <= 1'b1;
         end else if (scl_fall) begin
            start_hi_q <= 1'b0;
         end
      end
   end

   // ---------------- Byte engine ------------------------------------
   bus_state_t state_q;
   bus_state_t nxt_q;
   logic [3:0] bit_cnt_q;
   logic [7:0] shift_q;
   logic ack_q;
   cmd_t cmd_q;
   cmd_t rd_cmd_q;
   logic rd_armed_q;
   logic [7:0] tx_q;
   logic init_q;
   logic [7:0] vol_q [2];
   logic [7:0] nv_q [2];

   logic [7:0] byte_in;
   logic byte_done;
   logic addr_hit;
   logic commit;
   assign byte_in = {shift_q[6:0], bit_s};
   assign byte_done = bit_ev_q && (bit_cnt_q == LAST_DATA_BIT);
   // General call and ten-bit headers never carry the 010 prefix
   assign addr_hit = (byte_in[7:1] == {ADDR_PREFIX, sel_pins_s}) &&
                     init_q && !nv_busy;
   // The 26th rising clock is the last data bit of the third byte
   assign commit = byte_done && (state_q == st_data);

   // Frame position, decoded bytes and the next byte's role
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= st_idle;
         nxt_q <= st_ignore;
         bit_cnt_q <= 4'h0;
         shift_q <= 8'h00;
         ack_q <= 1'b0;
         cmd_q <= '0;
         rd_cmd_q <= '0;
         rd_armed_q <= 1'b0;
         tx_q <= 8'h00;
      end else if (clk_en) begin
         if (start_ev) begin
            // Fresh or repeated START both restart address decoding
            state_q <= st_addr;
            bit_cnt_q <= 4'h0;
            ack_q <= 1'b0;
         end else if (stop_ok) begin
            state_q <= st_idle;
            ack_q <= 1'b0;
            rd_armed_q <= 1'b0;
         end else if (bit_ev_q && state_q != st_idle) begin
            if (bit_cnt_q != ACK_SLOT) begin
               shift_q <= byte_in;
               bit_cnt_q <= bit_cnt_q + 4'h1;
               if (bit_cnt_q == LAST_DATA_BIT) begin
                  ack_q <= 1'b0;
                  nxt_q <= st_ignore;
                  case (state_q)
                     st_addr: begin
                        if (addr_hit && !byte_in[0]) begin
                           ack_q <= 1'b1;
                           nxt_q <= st_cmd;
                        end else if (addr_hit && rd_armed_q) begin
                           ack_q <= 1'b1;
                           nxt_q <= st_read;
                           tx_q <= rd_cmd_q.nonvolatile_select_bit ?
                              nv_q[rd_cmd_q.register_select_field[0]] :
                              vol_q[rd_cmd_q.register_select_field[0]];
                        end
                     end
                     st_cmd: begin
                        cmd_q <= cmd_t'(byte_in);
                        if (write_ok(cmd_t'(byte_in))) begin
                           ack_q <= 1'b1;
                           nxt_q <= st_data;
                        end else if (read_ok(cmd_t'(byte_in))) begin
                           ack_q <= 1'b1;
                           rd_armed_q <= 1'b1;
                           rd_cmd_q <= cmd_t'(byte_in);
                        end
                     end
                     st_data: begin
                        ack_q <= 1'b1;
                     end
                     st_read: begin
                        nxt_q <= st_read;
                     end
                     default: begin
                        nxt_q <= st_ignore;
                     end
                  endcase
               end
            end else begin
               // Acknowledge clock: a released line ends a read
               bit_cnt_q <= 4'h0;
               ack_q <= 1'b0;
               if (state_q == st_read && bit_s) begin
                  state_q <= st_ignore;
               end else begin
                  state_q <= nxt_q;
               end
            end
         end
      end
   end

   // ---------------- Data line driver -------------------------------
   logic sda_low_q;

   // Pulls only after the clock falls; a START or STOP releases it while the clock is high
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sda_low_q <= 1'b0;
      end else if (clk_en) begin
         if (start_ev || stop_ok) begin
            sda_low_q <= 1'b0;
         end else if (scl_fall) begin
            if (bit_cnt_q == ACK_SLOT) begin
               sda_low_q <= ack_q;
            end else if (state_q == st_read) begin
               sda_low_q <= ~tx_q[~bit_cnt_q[2:0]];
            end else begin
               sda_low_q <= 1'b0;
            end
         end
      end
   end

   // Open drain: only ever pulls low, never drives high
   assign sda_out = 1'b0;
   assign sda_oe_n = ~sda_low_q;

   // ---------------- Code registers ---------------------------------
   // One-shot power-up load; commands are refused until it has run
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         init_q <= 1'b0;
      end else if (clk_en) begin
         init_q <= 1'b1;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_dac
         // Nonvolatile copy reloads the volatile code before first use
         always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
               vol_q[gi] <= VOL_RESET;
               nv_q[gi] <= NV_RESET;
            end else if (clk_en) begin
               if (!init_q) begin
                  vol_q[gi] <= nv_q[gi];
               end else if (commit &&
                            sel_hits(cmd_q.register_select_field, gi)) begin
                  case ({cmd_q.nonvolatile_select_bit,
                         cmd_q.volatile_select_bit})
                     REG_COPY: vol_q[gi] <= nv_q[gi];
                     REG_VOL: vol_q[gi] <= byte_in;
                     REG_NV: nv_q[gi] <= byte_in;
                     REG_BOTH: begin
                        vol_q[gi] <= byte_in;
                        nv_q[gi] <= byte_in;
                     end
                     default: vol_q[gi] <= vol_q[gi];
                  endcase
               end
            end
         end
      end
   endgenerate

   assign dac_codes = {vol_q[1], vol_q[0]};
   assign nv_codes = {nv_q[1], nv_q[0]};

   // ---------------- Nonvolatile store busy time --------------------
   logic nv_pend_q;
   logic [CNT_W-1:0] busy_cnt_q;
   logic busy_q;

   // Store time is counted from the STOP that closes the write
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         nv_pend_q <= 1'b0;
         busy_cnt_q <= CNT_ZERO;
         busy_q <= 1'b0;
      end else if (clk_en) begin
         if (commit && cmd_q.nonvolatile_select_bit) begin
            nv_pend_q <= 1'b1;
         end else if (stop_ok) begin
            nv_pend_q <= 1'b0;
         end
         if (stop_ok && (nv_pend_q ||
             (commit && cmd_q.nonvolatile_select_bit))) begin
            busy_cnt_q <= BUSY_LOAD;
            busy_q <= 1'b1;
         end else if (busy_cnt_q != CNT_ZERO) begin
            busy_cnt_q <= busy_cnt_q - 24'h000001;
            busy_q <= (busy_cnt_q != 24'h000001);
         end
      end
   end

   // While busy the address is not acknowledged; controller retries
   assign nv_busy = busy_q;
   assign bus_active = (state_q != st_idle);

endmodule

// File: verif/dac_port_sva.sv
// Port-level checks for the dual DAC serial port
module dac_port_sva
   import dac_port_pkg::*;
#(
   parameter int BUSY_CNT = BUSY_CYCLES,
   parameter int NUM_SEL_PINS = ADDR_PINS
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic scl_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic [NUM_SEL_PINS-1:0] address_select_pins,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   input wire dac_codes_t dac_codes,
   input wire dac_codes_t nv_codes,
   input wire logic nv_busy,
   input wire logic bus_active
);
   timeunit 1ns;
   timeprecision 1ps;
   int busy_len_q;

   // Busy stretch length; holds while the reference logic is frozen
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         busy_len_q <= 0;
      end else if (!nv_busy) begin
         busy_len_q <= 0;
      end else if (clk_en) begin
         busy_len_q <= busy_len_q + 1;
      end
   end

   // Link domain: the pin may only ever pull low
   a_open_drain: assert property (
      @(posedge scl_clk) disable iff (!resetn) sda_out == 1'h0)
      else $error("data pin driven high");
   // Pull may move only while the bus clock is low
   a_pull_in_low: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      $changed(sda_oe_n) |-> !scl_in) else $error("pull moved");
   a_ack_holds: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      $rose(scl_in) && !sda_oe_n |-> !sda_oe_n [*8])
      else $error("pull released early");
   // Codes move only inside a frame, never on their own
   a_vol_in_frame: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      $changed(dac_codes) |-> bus_active) else $error("code moved");
   a_nv_in_frame: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      $changed(nv_codes) |-> bus_active) else $error("store moved");
   a_busy_bound: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      nv_busy |-> busy_len_q <= BUSY_CNT + 1) else $error("busy long");
   a_busy_nv_hold: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      nv_busy |=> $stable(nv_codes)) else $error("store in busy");
   a_freeze_holds: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      !clk_en |=> $stable(dac_codes) && $stable(nv_busy))
      else $error("state moved while frozen");
   a_idle_quiet: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      !bus_active |-> sda_oe_n) else $error("pull while idle");
endmodule

// File: verif/bus_ctl_model.sv
// Bus controller model: makes the bus clock and pulls the data line
module bus_ctl_model (
   output logic scl,
   output logic sda_low,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   // Odd quarter period keeps bus edges drifting against ref_clk
   localparam int QTR = 627;

   // Both lines idle high
   initial begin
      scl = 1'h1;
      sda_low = 1'h0;
   end

   // One bit: data set while clock low, read at mid high
   task clk_bit(input logic b, output logic r);
      sda_low = !b;
      #QTR;
      scl = 1'h1;
      #QTR;
      r = sda;
      #QTR;
      scl = 1'h0;
      #QTR;
   endtask

   // Start or repeated start: data falls with clock high
   task bus_start();
      sda_low = 1'h0;
      #QTR;
      scl = 1'h1;
      #QTR;
      sda_low = 1'h1;
      #QTR;
      scl = 1'h0;
      #QTR;
   endtask

   // Stop: data rises with clock high, then bus free time
   task bus_stop();
      sda_low = 1'h1;
      #QTR;
      scl = 1'h1;
      #QTR;
      sda_low = 1'h0;
      #(4*QTR);
   endtask

   // Byte out MSB first, then the line is released for the answer
   task put_byte(input logic [7:0] v, output logic ack_n);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(v[i], r);
      end
      clk_bit(1'h1, ack_n);
   endtask

   // Byte in, then our own acknowledge or refusal
   task get_byte(input logic nack, output logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         clk_bit(1'h1, r);
         v[i] = r;
      end
      clk_bit(nack, r);
   endtask
endmodule

// File: verif/dual_dac_serial_register_port_bench.sv
// Self-checking bench for the dual DAC serial port
module dual_dac_serial_register_port_bench
   import dac_port_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   // Short store time keeps the run brief
   localparam int BUSY = 1000;
   localparam logic [3:0] PINS = 4'hB;
   localparam logic [7:0] AW = {ADDR_PREFIX, PINS, 1'h0};
   localparam logic [7:0] AR = {ADDR_PREFIX, PINS, 1'h1};
   logic ref_clk, resetn, clk_en, scl, sda_low, sda, sda_out, sda_oe_n;
   logic nv_busy, bus_active;
   dac_codes_t dac_codes, nv_codes;
   logic [2:0] k;
   logic [7:0] d;
   int num_errors = 0;
   int n_tests = 0;
   int cycles = 0;

   // Wired-AND data line with pull-up
   assign sda = (sda_low || (!sda_oe_n && !sda_out)) ? 1'h0 : 1'h1;

   dual_dac_serial_register_port #(.BUSY_CNT(BUSY), .NUM_SEL_PINS(4))
      dual_dac_serial_register_port_inst (.ref_clk(ref_clk),
      .resetn(resetn), .clk_en(clk_en), .scl_clk(scl), .scl_in(scl),
      .sda_in(sda), .address_select_pins(PINS), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .dac_codes(dac_codes), .nv_codes(nv_codes),
      .nv_busy(nv_busy), .bus_active(bus_active));
   bus_ctl_model bus_ctl_model_inst (.scl(scl), .sda_low(sda_low),
      .sda(sda));

   initial begin
      ref_clk = 1'h0;
      forever #25 ref_clk = ~ref_clk;
   end

   task end_sim();
      if (num_errors == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task check(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task wr(input logic [7:0] a, input logic [7:0] c, input logic [7:0] v);
      bus_ctl_model_inst.bus_start();
      bus_ctl_model_inst.put_byte(a, k[2]);
      bus_ctl_model_inst.put_byte(c, k[1]);
      bus_ctl_model_inst.put_byte(v, k[0]);
   endtask

   // Stop, then let the synchronisers catch up
   task sp();
      bus_ctl_model_inst.bus_stop();
      repeat (10) @(posedge ref_clk);
   endtask

   task rd(input logic [7:0] c);
      bus_ctl_model_inst.bus_start();
      bus_ctl_model_inst.put_byte(AW, k[2]);
      bus_ctl_model_inst.put_byte(c, k[1]);
      bus_ctl_model_inst.bus_start();
      bus_ctl_model_inst.put_byte(AR, k[0]);
      bus_ctl_model_inst.get_byte(1'h1, d);
      sp();
   endtask

   task busy_wait();
      for (int i = 0; i < 3000 && nv_busy !== 1'h0; i++) begin
         @(posedge ref_clk);
      end
      check(nv_busy, 1'h0);
   endtask

   task t_vol();
      wr(AW, {OP_WRITE, REG_VOL, SEL_DAC0}, 8'hA5);
      check(k, 3'h0);
      check(dac_codes, 16'h00A5);
      // Bus stays occupied until the STOP frees it
      check(bus_active, 1'h1);
      sp();
      check(bus_active, 1'h0);
      check(nv_codes, 16'h0000);
   endtask

   task t_nv();
      wr(AW, {OP_WRITE, REG_VOL, SEL_ALL}, 8'h3C);
      sp();
      check(dac_codes, 16'h3C3C);
      wr(AW, {OP_WRITE, REG_NV, SEL_DAC1}, 8'h5A);
      sp();
      check(nv_codes, 16'h5A00);
      check(dac_codes, 16'h3C3C);
      check(nv_busy, 1'h1);
      // Address is refused during the store; retried later
      bus_ctl_model_inst.bus_start();
      bus_ctl_model_inst.put_byte(AW, k[0]);
      sp();
      check(k[0], 1'h1);
      #2 clk_en = 1'h0;
      repeat (5) @(posedge ref_clk);
      #2 clk_en = 1'h1;
      busy_wait();
   endtask

   task t_copy();
      wr(AW, {OP_WRITE, REG_COPY, SEL_DAC1}, 8'hFF);
      sp();
      check(dac_codes, 16'h5A3C);
      wr(AW, {OP_WRITE, REG_BOTH, SEL_DAC0}, 8'h77);
      sp();
      check(dac_codes, 16'h5A77);
      check(nv_codes, 16'h5A77);
      busy_wait();
   endtask

   task t_read();
      rd({OP_READ, REG_NV, SEL_DAC1});
      check(k, 3'h0);
      check(d, 8'h5A);
      rd({OP_READ, REG_VOL, SEL_DAC0});
      check(d, 8'h77);
      // Read direction with no read command pending is refused
      bus_ctl_model_inst.bus_start();
      bus_ctl_model_inst.put_byte(AR, k[0]);
      sp();
      check(k[0], 1'h1);
   endtask

   // General call, wrong fixed bits, wrong select pins
   task t_foreign();
      logic [7:0] bad [3] = '{8'h00, {3'h3, PINS, 1'h0},
         {ADDR_PREFIX, ~PINS, 1'h0}};
      foreach (bad[i]) begin
         wr(bad[i], {OP_WRITE, REG_VOL, SEL_DAC0}, 8'h11);
         sp();
         check(k, 3'h7);
         check(dac_codes, 16'h5A77);
      end
      // All-converter select is only legal for volatile-only writes
      wr(AW, {OP_WRITE, REG_NV, SEL_ALL}, 8'h11);
      sp();
      check(k, 3'h3);
      check(nv_codes, 16'h5A77);
   endtask

   task t_abort_chain();
      logic r;
      bus_ctl_model_inst.bus_start();
      bus_ctl_model_inst.put_byte(AW, k[2]);
      bus_ctl_model_inst.put_byte({OP_WRITE, REG_VOL, SEL_DAC1}, k[1]);
      repeat (4) bus_ctl_model_inst.clk_bit(1'h0, r);
      sp();
      check(dac_codes, 16'h5A77);
      wr(AW, {OP_WRITE, REG_VOL, SEL_DAC0}, 8'h12);
      wr(AW, {OP_WRITE, REG_VOL, SEL_DAC1}, 8'h34);
      sp();
      check(k, 3'h0);
      check(dac_codes, 16'h3412);
   endtask

   // Cut a hang short well past the expected run length
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 60000) begin
         num_errors++;
         end_sim();
      end
   end

   initial begin
      resetn = 1'h0;
      clk_en = 1'h1;
      repeat (6) @(posedge ref_clk);
      #2 resetn = 1'h1;
      repeat (8) @(posedge ref_clk);
      // Volatile codes start from the stored copies
      check(dac_codes, {NV_RESET, NV_RESET});
      check(nv_codes, {NV_RESET, NV_RESET});
      t_vol();
      t_nv();
      t_copy();
      t_read();
      t_foreign();
      t_abort_chain();
      end_sim();
   end
endmodule

bind dual_dac_serial_register_port dac_port_sva #(.BUSY_CNT(BUSY_CNT),
   .NUM_SEL_PINS(NUM_SEL_PINS)) dac_port_sva_inst (.ref_clk(ref_clk),
   .resetn(resetn), .clk_en(clk_en), .scl_clk(scl_clk), .scl_in(scl_in),
   .sda_in(sda_in), .address_select_pins(address_select_pins),
   .sda_out(sda_out), .sda_oe_n(sda_oe_n), .dac_codes(dac_codes),
   .nv_codes(nv_codes), .nv_busy(nv_busy), .bus_active(bus_active));
